// >>> include/pfrc_pkg.sv
// Package of constants for the parity and reference clock control block
package pfrc_pkg;
    // Three-level select codes
    localparam logic [1:0] SEL_LOW  = 2'h0;
    localparam logic [1:0] SEL_MID  = 2'h1;
    localparam logic [1:0] SEL_HIGH = 2'h2;

    // Channel and data widths
    localparam int NCH    = 2;
    localparam int CHAR_W = 8;
    localparam int TCTL_W = 2;
    localparam int STAT_W = 3;
    localparam int RAW_W  = 10;
    localparam int WORD_W = 11;
    localparam int MEM_W  = 12;
    localparam int FRM_B  = 11;

    // Elasticity buffer geometry and fill marks
    localparam int         EB_AW      = 3;
    localparam int         EB_DEPTH   = 8;
    localparam int         PTR_W      = 4;
    localparam logic [3:0] EB_LOW_MK  = 4'h2;
    localparam logic [3:0] EB_HIGH_MK = 4'h6;

    // Inserted framing character in decoded and raw form
    localparam logic [7:0] K285_CHAR = 8'hBC;
    localparam logic [2:0] K285_STAT = 3'h1;
    localparam logic [9:0] K285_RAW  = 10'h0FA;

    // Register byte addresses
    localparam int         ADR_W    = 8;
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h04;
    localparam logic [7:0] ADR_MASK = 8'h08;
    localparam logic [7:0] ADR_STATE = 8'h0C;

    // Control register fields
    localparam int          CTRL_W   = 13;
    localparam int          F_PAR    = 0;
    localparam int          F_TXOP   = 2;
    localparam int          F_DEC    = 4;
    localparam int          F_RATE   = 6;
    localparam int          F_TXCK   = 8;
    localparam int          F_RXCK   = 10;
    localparam int          F_TX_REF_RATE_SEL = 12;
    localparam logic [12:0] CTRL_RST = 13'h0094;

    // Status and mask fields
    localparam int         ST_W    = 7;
    localparam int         ST_TXPE = 0;
    localparam int         ST_INS  = 2;
    localparam int         ST_DEL  = 4;
    localparam int         ST_CFG  = 6;
    localparam logic [6:0] ST_RST  = 7'h00;

    // State register fields and PLL range codes
    localparam int         S_FILL  = 0;
    localparam int         S_PLL   = 8;
    localparam logic [2:0] PLL_LO  = 3'h1;
    localparam logic [2:0] PLL_MID = 3'h2;
    localparam logic [2:0] PLL_HI  = 3'h4;
endpackage : pfrc_pkg

// >>> design/pfrc_ebuf_mem.sv
// Elasticity buffer storage with registered read data
`timescale 1ns/1ps
module pfrc_ebuf_mem
    import pfrc_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             wr_en,
    input  wire logic [EB_AW-1:0] wr_addr,
    input  wire logic [MEM_W-1:0] wr_data,
    input  wire logic             rd_en,
    input  wire logic [EB_AW-1:0] rd_addr,
    output logic      [MEM_W-1:0] rd_data
);
    logic [MEM_W-1:0] mem_r [EB_DEPTH];

    // Write port, no reset on the array
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    // Read port, data valid the cycle after rd_en
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= mem_r[rd_addr];
        end
    end
endmodule : pfrc_ebuf_mem

// >>> design/pfrc_top.sv
// Parity check/generate, reference clock selection and elasticity buffer control
`timescale 1ns/1ps
module pfrc_top
    import pfrc_pkg::*;
(
    input  wire logic                   REF_CLK,
    input  wire logic                   RESET_N,
    input  wire logic                   WB_CYC_I,
    input  wire logic                   WB_STB_I,
    input  wire logic                   WB_WE_I,
    input  wire logic [ADR_W-1:0]       WB_ADR_I,
    input  wire logic [3:0]             WB_SEL_I,
    input  wire logic [31:0]            WB_DAT_I,
    output logic      [31:0]            WB_DAT_O,
    output logic                        WB_ACK_O,
    output logic                        IRQ,
    input  wire logic [NCH*CHAR_W-1:0]  TX_CHAR_IN,
    input  wire logic [NCH*TCTL_W-1:0]  TX_CTRL_IN,
    input  wire logic [NCH-1:0]         TX_PARITY_IN,
    input  wire logic [NCH-1:0]         TX_VALID_IN,
    output logic      [NCH*RAW_W-1:0]   TX_WORD_OUT,
    output logic      [NCH-1:0]         TX_VALID_OUT,
    output logic      [NCH-1:0]         TX_PARITY_ERR,
    input  wire logic [NCH*WORD_W-1:0]  RX_IN_WORD,
    input  wire logic [NCH-1:0]         RX_IN_FRAMING,
    input  wire logic [NCH-1:0]         RX_IN_VALID,
    output logic      [NCH*CHAR_W-1:0]  RX_CHAR_OUT,
    output logic      [NCH*STAT_W-1:0]  RX_STATUS_OUT,
    output logic      [NCH-1:0]         RX_VALID_OUT,
    output logic      [NCH-1:0]         RX_PARITY_OUT,
    output logic      [NCH-1:0]         RX_PARITY_OE,
    output logic                        DELAYED_REF_CLOCK_OUT,
    output logic                        DELAYED_REF_CLOCK_OE,
    output logic      [2:0]             PLL_RANGE_OUT
);
    // Register state
    logic [CTRL_W-1:0] ctrl_r;
    logic [CTRL_W-1:0] ctrl_nxt;
    logic [ST_W-1:0]   status_r;
    logic [ST_W-1:0]   status_nxt;
    logic [ST_W-1:0]   mask_r;
    logic [ST_W-1:0]   mask_nxt;
    logic              ack_r;
    logic [31:0]       dat_r;
    logic [2:0]        pll_r;

    // Decoded select fields
    wire [1:0] parity_control_sel  = ctrl_r[F_PAR +: 2];
    wire [1:0] tx_operating_sel    = ctrl_r[F_TXOP +: 2];
    wire [1:0] decoder_sel         = ctrl_r[F_DEC +: 2];
    wire [1:0] line_rate_range_sel = ctrl_r[F_RATE +: 2];
    wire [1:0] tx_clock_source_sel = ctrl_r[F_TXCK +: 2];
    wire [1:0] rx_clock_source_sel = ctrl_r[F_RXCK +: 2];
    wire       tx_ref_rate_sel     = ctrl_r[F_TX_REF_RATE_SEL];

    // Mode terms shared by all channels
    wire par_on     = (parity_control_sel != SEL_LOW);
    wire codec_off  = (tx_operating_sel == SEL_LOW) && (decoder_sel == SEL_LOW);
    wire cover_ctl  = (parity_control_sel == SEL_HIGH)
                    || ((parity_control_sel == SEL_MID) && codec_off);
    wire cover_st2  = (parity_control_sel == SEL_HIGH);
    wire tx_ref_clk = (tx_clock_source_sel == SEL_LOW);
    wire buf_on     = (rx_clock_source_sel == SEL_LOW);
    wire dec_byp    = (decoder_sel == SEL_LOW);

    // Per-channel event vectors
    logic [NCH-1:0]       ins_ev;
    logic [NCH-1:0]       del_ev;
    logic [NCH*PTR_W-1:0] fill_all;

    // Wishbone decode and byte lane mask
    wire        wb_req   = WB_CYC_I && WB_STB_I;
    wire        wr_fire  = wb_req && WB_WE_I && ack_r;
    wire        hit_ctrl = (WB_ADR_I == ADR_CTRL);
    wire        hit_stat = (WB_ADR_I == ADR_STAT);
    wire        hit_mask = (WB_ADR_I == ADR_MASK);
    wire        hit_st   = (WB_ADR_I == ADR_STATE);
    wire [31:0] wmask    = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                            {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    wire [31:0] wdat_m   = WB_DAT_I & wmask;

    // Read data selection, unmapped addresses read zero
    wire [31:0] state_word = {21'h000000, pll_r, fill_all};
    wire [31:0] rd_mux = hit_ctrl ? {19'h00000, ctrl_r}
                       : hit_stat ? {25'h0000000, status_r}
                       : hit_mask ? {25'h0000000, mask_r}
                       : hit_st   ? state_word
                       : 32'h00000000;

    // Invalid half-rate selection is flagged as a status event
    wire cfg_ev = (line_rate_range_sel == SEL_LOW) && tx_ref_rate_sel;

    // Event sources gathered in status layout
    wire [ST_W-1:0] events = {cfg_ev, del_ev, ins_ev, TX_PARITY_ERR};
    wire [ST_W-1:0] w1c    = (wr_fire && hit_stat) ? wdat_m[ST_W-1:0] : '0;

    // Next values; a new event wins over a clear in the same cycle
    always_comb begin
        ctrl_nxt   = ctrl_r;
        mask_nxt   = mask_r;
        status_nxt = (status_r & ~w1c) | events;
        if (wr_fire && hit_ctrl) begin
            ctrl_nxt = (ctrl_r & ~wmask[CTRL_W-1:0]) | wdat_m[CTRL_W-1:0];
        end
        if (wr_fire && hit_mask) begin
            mask_nxt = (mask_r & ~wmask[ST_W-1:0]) | wdat_m[ST_W-1:0];
        end
    end

    // Bus slave handshake and register update
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ack_r    <= 1'b0;
            dat_r    <= 32'h00000000;
            ctrl_r   <= CTRL_RST;
            status_r <= ST_RST;
            mask_r   <= ST_RST;
        end else begin
            ack_r    <= wb_req && !ack_r;
            if (wb_req && !ack_r) begin
                dat_r <= rd_mux;
            end
            ctrl_r   <= ctrl_nxt;
            status_r <= status_nxt;
            mask_r   <= mask_nxt;
        end
    end

    // PLL range follows the line rate select
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pll_r <= PLL_HI;
        end else begin
            case (line_rate_range_sel)
                SEL_LOW: pll_r <= PLL_LO;
                SEL_MID: pll_r <= PLL_MID;
                default: pll_r <= PLL_HI;
            endcase
        end
    end

    // Bus and system outputs
    assign WB_ACK_O              = ack_r;
    assign WB_DAT_O              = dat_r;
    assign IRQ                   = |(status_r & mask_r);
    assign PLL_RANGE_OUT         = pll_r;
    assign DELAYED_REF_CLOCK_OUT = REF_CLK & buf_on;
    assign DELAYED_REF_CLOCK_OE  = buf_on;

    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            // Transmit path
            logic [RAW_W-1:0] tx_word_r;
            logic             tx_vld_r;
            logic             tx_perr_r;
            wire  [CHAR_W-1:0] tx_ch  = TX_CHAR_IN[c*CHAR_W +: CHAR_W];
            wire  [TCTL_W-1:0] tx_ct  = TX_CTRL_IN[c*TCTL_W +: TCTL_W];
            wire               tx_go  = TX_VALID_IN[c] && tx_ref_clk;
            wire  [TCTL_W-1:0] ct_cov = tx_ct & {TCTL_W{cover_ctl}};
            wire               tx_odd = ^{tx_ch, ct_cov, TX_PARITY_IN[c]};

            // Capture transmit data and flag parity violations
            always_ff @(posedge REF_CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    tx_word_r <= '0;
                    tx_vld_r  <= 1'b0;
                    tx_perr_r <= 1'b0;
                end else begin
                    tx_vld_r  <= tx_go;
                    tx_perr_r <= tx_go && par_on && !tx_odd;
                    if (tx_go) begin
                        tx_word_r <= {tx_ct, tx_ch};
                    end
                end
            end

            assign TX_WORD_OUT[c*RAW_W +: RAW_W] = tx_word_r;
            assign TX_VALID_OUT[c]               = tx_vld_r;
            assign TX_PARITY_ERR[c]              = tx_perr_r;

            // Elasticity buffer pointers and flow
            logic [PTR_W-1:0]  wr_ptr_r;
            logic [PTR_W-1:0]  rd_ptr_r;
            logic              rd_vld_r;
            logic              ins_r;
            logic [MEM_W-1:0]  rd_data;
            wire  [PTR_W-1:0]  fill    = wr_ptr_r - rd_ptr_r;
            wire  [WORD_W-1:0] in_word = RX_IN_WORD[c*WORD_W +: WORD_W];
            wire               drop    = RX_IN_FRAMING[c] && (fill >= EB_HIGH_MK);
            wire               wr_en   = buf_on && RX_IN_VALID[c] && !drop;
            wire               frm_now = rd_vld_r && rd_data[FRM_B];
            wire               ins     = buf_on && (fill < EB_LOW_MK) && frm_now;
            wire               rd_en   = buf_on && !ins && (fill != '0);

            assign ins_ev[c] = ins;
            assign del_ev[c] = buf_on && RX_IN_VALID[c] && drop;
            assign fill_all[c*PTR_W +: PTR_W] = fill;

            // Pointer update; both collapse to zero while the buffer is off
            always_ff @(posedge REF_CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    wr_ptr_r <= '0;
                    rd_ptr_r <= '0;
                    rd_vld_r <= 1'b0;
                    ins_r    <= 1'b0;
                end else if (!buf_on) begin
                    wr_ptr_r <= '0;
                    rd_ptr_r <= '0;
                    rd_vld_r <= 1'b0;
                    ins_r    <= 1'b0;
                end else begin
                    wr_ptr_r <= wr_ptr_r + (wr_en ? 4'h1 : 4'h0);
                    rd_ptr_r <= rd_ptr_r + (rd_en ? 4'h1 : 4'h0);
                    rd_vld_r <= rd_en;
                    ins_r    <= ins;
                end
            end

            pfrc_ebuf_mem u_mem (
                .clk     (REF_CLK),
                .rst_n   (RESET_N),
                .wr_en   (wr_en),
                .wr_addr (wr_ptr_r[EB_AW-1:0]),
                .wr_data ({RX_IN_FRAMING[c], in_word}),
                .rd_en   (rd_en),
                .rd_addr (rd_ptr_r[EB_AW-1:0]),
                .rd_data (rd_data)
            );

            // Output source: buffer word, inserted K28.5, or direct input
            wire [WORD_W-1:0] k_word  = dec_byp ? {1'b0, K285_RAW}
                                                : {K285_STAT, K285_CHAR};
            wire [WORD_W-1:0] src     = !buf_on ? in_word
                                      : ins_r   ? k_word
                                      : rd_data[WORD_W-1:0];
            wire              src_vld = buf_on ? (rd_vld_r || ins_r) : RX_IN_VALID[c];
            wire [WORD_W-1:0] fmt     = dec_byp ? {1'b0, src[RAW_W-1:0]} : src;
            wire [STAT_W-1:0] st_cov  = {fmt[WORD_W-1] & cover_st2,
                                         fmt[CHAR_W +: 2] & {2{cover_ctl}}};
            wire              rx_par  = ~^{fmt[CHAR_W-1:0], st_cov};

            // Receive output register with parity
            logic [WORD_W-1:0] rx_out_r;
            logic              rx_vld_r;
            logic              rx_par_r;
            always_ff @(posedge REF_CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    rx_out_r <= '0;
                    rx_vld_r <= 1'b0;
                    rx_par_r <= 1'b0;
                end else begin
                    rx_vld_r <= src_vld;
                    if (src_vld) begin
                        rx_out_r <= fmt;
                        rx_par_r <= rx_par;
                    end
                end
            end

            assign RX_CHAR_OUT[c*CHAR_W +: CHAR_W]   = rx_out_r[CHAR_W-1:0];
            assign RX_STATUS_OUT[c*STAT_W +: STAT_W] = rx_out_r[WORD_W-1:CHAR_W];
            assign RX_VALID_OUT[c]                   = rx_vld_r;
            assign RX_PARITY_OUT[c]                  = rx_par_r;
            assign RX_PARITY_OE[c]                   = par_on;
        end
    endgenerate
endmodule : pfrc_top

// >>> sim/pfrc_host_model.sv
// Host-side transmit driver that attaches odd parity to each character
`timescale 1ns/1ps
module pfrc_host_model
    import pfrc_pkg::*;
(
    input  wire logic                  clk,
    output logic      [NCH*CHAR_W-1:0] tx_char,
    output logic      [NCH*TCTL_W-1:0] tx_ctrl,
    output logic      [NCH-1:0]        tx_par,
    output logic      [NCH-1:0]        tx_val
);
    // Idle lines at time zero
    initial begin
        {tx_char, tx_ctrl, tx_par, tx_val} = '0;
    end

    // Same character on both lanes; lane 0 parity inverted when bad is set
    task automatic send(input logic [7:0] ch, input logic [1:0] ct, input logic cov,
                        input logic bad);
        logic p;
        p = ~^{ch, ct & {2{cov}}};
        @(posedge clk);
        {tx_char, tx_ctrl, tx_par, tx_val} <= {ch, ch, ct, ct, p, p ^ bad, 2'h3};
        @(posedge clk);
        {tx_char, tx_ctrl, tx_val} <= {~ch, ~ch, ~ct, ~ct, 2'h0}; // Stale data scrambled
    endtask : send
endmodule : pfrc_host_model

// >>> sim/pfrc_top_checker.sv
// Concurrent checks on the ports of the parity and reference clock block
`timescale 1ns/1ps
module pfrc_top_checker
    import pfrc_pkg::*;
(
    input wire logic                  REF_CLK,
    input wire logic                  RESET_N,
    input wire logic                  WB_CYC_I,
    input wire logic                  WB_STB_I,
    input wire logic                  WB_WE_I,
    input wire logic [ADR_W-1:0]      WB_ADR_I,
    input wire logic [3:0]            WB_SEL_I,
    input wire logic [31:0]           WB_DAT_I,
    input wire logic                  WB_ACK_O,
    input wire logic [NCH-1:0]        TX_VALID_IN,
    input wire logic [NCH-1:0]        TX_VALID_OUT,
    input wire logic [NCH-1:0]        TX_PARITY_ERR,
    input wire logic [NCH-1:0]        RX_IN_FRAMING,
    input wire logic [NCH-1:0]        RX_IN_VALID,
    input wire logic [NCH*CHAR_W-1:0] RX_CHAR_OUT,
    input wire logic [NCH*STAT_W-1:0] RX_STATUS_OUT,
    input wire logic [NCH-1:0]        RX_VALID_OUT,
    input wire logic [NCH-1:0]        RX_PARITY_OUT,
    input wire logic [NCH-1:0]        RX_PARITY_OE,
    input wire logic                  DELAYED_REF_CLOCK_OUT,
    input wire logic                  DELAYED_REF_CLOCK_OE,
    input wire logic [2:0]            PLL_RANGE_OUT
);
    logic [CTRL_W-1:0] ctrl_r;
    // Shadow of the control register, updated by acked writes per byte lane
    wire               wr_w = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O & (WB_ADR_I == ADR_CTRL);
    wire [CTRL_W-1:0]  ctrl_nxt = {WB_SEL_I[1] ? WB_DAT_I[12:8] : ctrl_r[12:8],
                                   WB_SEL_I[0] ? WB_DAT_I[7:0] : ctrl_r[7:0]};
    wire [1:0]         par = ctrl_r[F_PAR+:2];
    wire [1:0]         txck = ctrl_r[F_TXCK+:2];
    wire [1:0]         rxck = ctrl_r[F_RXCK+:2];
    wire [1:0]         rate = ctrl_r[F_RATE+:2];
    wire               cov = (par == SEL_HIGH) || (par == SEL_MID
                             && ctrl_r[F_TXOP+:2] == SEL_LOW && ctrl_r[F_DEC+:2] == SEL_LOW);
    wire [2:0]         pll_exp = (rate == SEL_LOW) ? PLL_LO : (rate == SEL_MID) ? PLL_MID : PLL_HI;

    // Shadow register flop
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) ctrl_r <= CTRL_RST;
        else if (wr_w) ctrl_r <= ctrl_nxt;
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);

    AST_PAR_OE: assert property ($stable(par) |-> RX_PARITY_OE == {2{par != SEL_LOW}})
        else $error("parity pin enable does not follow parity select");
    AST_TX_CAP: assert property (TX_VALID_OUT == ($past(TX_VALID_IN)
        & {2{$past(txck) == SEL_LOW}})) else $error("transmit capture mismatch");
    AST_TX_ERR: assert property ((TX_PARITY_ERR & ~TX_VALID_OUT) == 2'h0
        && (TX_PARITY_ERR == 2'h0 || $past(par) != SEL_LOW)) else $error("stray parity error");
    AST_RX_PAR: assert property (RX_VALID_OUT[0] && par != SEL_LOW |->
        RX_PARITY_OUT[0] == ~^{RX_CHAR_OUT[7:0], RX_STATUS_OUT[1:0] & {2{cov}},
        RX_STATUS_OUT[2] & (par == SEL_HIGH)}) else $error("receive parity wrong");
    AST_RX_DIR: assert property ($stable(rxck) && rxck != SEL_LOW && RX_IN_VALID[0]
        |=> RX_VALID_OUT[0]) else $error("direct receive output late");
    AST_RX_BUF: assert property ($stable(rxck) && rxck == SEL_LOW && RX_IN_VALID[0]
        && !RX_IN_FRAMING[0] |-> ##[1:8] RX_VALID_OUT[0]) else $error("buffered data lost");
    AST_DLY_CLK: assert property (@(negedge REF_CLK) disable iff (!RESET_N)
        DELAYED_REF_CLOCK_OUT == DELAYED_REF_CLOCK_OE) else $error("delayed clock gating");
    AST_DLY_OE: assert property ($stable(rxck) |->
        DELAYED_REF_CLOCK_OE == (rxck == SEL_LOW)) else $error("delayed clock enable wrong");
    AST_PLL: assert property ($stable(rate) |-> PLL_RANGE_OUT == pll_exp)
        else $error("PLL range does not follow line rate select");
endmodule : pfrc_top_checker

// >>> sim/pfrc_top_tb.sv
// Self-checking bench for the parity and reference clock control block
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (a), (b)); end end
module pfrc_top_tb
    import pfrc_pkg::*;
();
    logic        ref_clk, reset_n, cyc, stb, we, ack, irq, dly_clk, dly_oe;
    logic [7:0]  adr;
    logic [3:0]  sel, tx_ctrl;
    logic [31:0] wdat, rdat, rv;
    logic [15:0] tx_char, rx_char;
    logic [1:0]  tx_par, tx_val, tx_vout, tx_err, rx_frm, rx_val, rx_vout, rx_par, rx_oe;
    logic [19:0] tx_word;
    logic [21:0] rx_word;
    logic [5:0]  rx_stat;
    logic [2:0]  pll;
    logic [11:0] q0, q1;
    int          n, err_total, check_count;

    pfrc_top u_pfrc_top (.REF_CLK(ref_clk), .RESET_N(reset_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .IRQ(irq), .TX_CHAR_IN(tx_char), .TX_CTRL_IN(tx_ctrl),
        .TX_PARITY_IN(tx_par), .TX_VALID_IN(tx_val), .TX_WORD_OUT(tx_word),
        .TX_VALID_OUT(tx_vout), .TX_PARITY_ERR(tx_err), .RX_IN_WORD(rx_word),
        .RX_IN_FRAMING(rx_frm), .RX_IN_VALID(rx_val), .RX_CHAR_OUT(rx_char),
        .RX_STATUS_OUT(rx_stat), .RX_VALID_OUT(rx_vout), .RX_PARITY_OUT(rx_par),
        .RX_PARITY_OE(rx_oe), .DELAYED_REF_CLOCK_OUT(dly_clk), .DELAYED_REF_CLOCK_OE(dly_oe),
        .PLL_RANGE_OUT(pll));
    pfrc_host_model u_pfrc_host_model (.clk(ref_clk), .tx_char(tx_char), .tx_ctrl(tx_ctrl),
        .tx_par(tx_par), .tx_val(tx_val));

    // Clock and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        #(50 * 4000);
        err_total++;
        test_done();
    end

    // Classic single Wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int k;
        k = 0;
        @(posedge ref_clk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
        do begin
            @(posedge ref_clk);
            k++;
        end while (ack !== 1'b1 && k < 16);
        q = rdat;
        {cyc, stb} <= 2'b00;
        `CHK(k < 16, 1'b1)
    endtask : wb

    // Control write; half-rate reference is never selected
    task automatic cfg(input logic [1:0] p, o, d, r, tc, rc);
        wb(1'b1, ADR_CTRL, {19'h0, 1'b0, rc, tc, r, d, o, p}, rv);
    endtask : cfg

    // One receive word on both lanes, then the lane 0 outputs are gathered for eight cycles
    task automatic rx_go(input logic [10:0] w, input logic f);
        @(posedge ref_clk);
        {rx_word, rx_frm, rx_val} <= {w, w, f, f, 2'h3};
        @(posedge ref_clk);
        {rx_word, rx_frm, rx_val} <= {~w, ~w, 4'h0};
        n = 0;
        repeat (8) begin
            @(negedge ref_clk);
            if (rx_vout[0] === 1'b1) begin
                q1 = {rx_par[0], rx_stat[2:0], rx_char[7:0]};
                if (n == 0) q0 = q1;
                n++;
            end
        end
    endtask : rx_go

    // Control register reset value, unmapped read, then each three-level select code
    task automatic t_static();
        wb(1'b0, ADR_CTRL, 32'h0, rv);
        `CHK(rv, {19'h0, CTRL_RST})
        wb(1'b0, 8'h10, 32'h0, rv);
        `CHK(rv, 32'h0)
        for (int i = 0; i < 3; i++) begin
            cfg(i[1:0], 2'h1, 2'h1, i[1:0], 2'h0, i[1:0]);
            repeat (2) @(posedge ref_clk);
            @(negedge ref_clk);
            `CHK({rx_oe, dly_oe}, {{2{i != 0}}, i == 0})
            `CHK(pll, {i == 2, i == 1, i == 0})
        end
    endtask : t_static

    // Good and bad parity in every parity mode, then a disabled transmit clock
    task automatic t_tx();
        logic [1:0] p;
        logic [1:0] o;
        for (int i = 0; i < 8; i++) begin
            p = (i < 2) ? SEL_LOW : (i < 6) ? SEL_MID : SEL_HIGH;
            o = (i == 4 || i == 5) ? SEL_LOW : SEL_MID;
            cfg(p, o, o, SEL_HIGH, SEL_LOW, SEL_LOW);
            u_pfrc_host_model.send(8'h5A ^ i[7:0], 2'h1, p == SEL_HIGH || o == SEL_LOW, i[0]);
            @(negedge ref_clk);
            `CHK(tx_vout, 2'h3)
            `CHK(tx_err, {1'b0, i[0] & (p != SEL_LOW)})
            `CHK(tx_word, {2{2'h1, 8'h5A ^ i[7:0]}})
        end
        cfg(SEL_MID, 2'h1, 2'h1, SEL_HIGH, SEL_MID, SEL_LOW);
        u_pfrc_host_model.send(8'h00, 2'h0, 1'b0, 1'b1);
        @(negedge ref_clk);
        `CHK({tx_vout, tx_err}, 4'h0)
    endtask : t_tx

    // Sticky parity error status, mask and write-one clear
    task automatic t_irq();
        wb(1'b0, ADR_STAT, 32'h0, rv);
        `CHK({rv, irq}, {32'h1, 1'b0})
        wb(1'b1, ADR_MASK, 32'h1, rv);
        @(negedge ref_clk);
        `CHK(irq, 1'b1)
        wb(1'b1, ADR_STAT, 32'h1, rv);
        @(negedge ref_clk);
        `CHK(irq, 1'b0)
    endtask : t_irq

    // Direct receive path: decoded and raw words under each parity coverage
    task automatic t_rx();
        logic [1:0] p;
        logic [1:0] d;
        logic [2:0] st;
        logic [11:0] ex;
        for (int i = 0; i < 3; i++) begin
            p = (i == 0) ? SEL_HIGH : SEL_MID;
            d = (i == 2) ? SEL_LOW : SEL_MID;
            cfg(p, d, d, SEL_HIGH, SEL_LOW, SEL_MID);
            rx_go(11'h5A5, 1'b0);
            st = (d == SEL_LOW) ? 3'h1 : 3'h5;
            ex = {~^{8'hA5, st[1:0] & {2{p == SEL_HIGH || d == SEL_LOW}},
                  st[2] & (p == SEL_HIGH)}, st, 8'hA5};
            `CHK(n, 1)
            `CHK(q0, ex)
        end
    endtask : t_rx

    // Buffered path: plain word passes alone, framing word gains a K28.5
    task automatic t_ebuf();
        cfg(SEL_MID, 2'h1, 2'h1, SEL_HIGH, SEL_LOW, SEL_LOW);
        rx_go(11'h055, 1'b0);
        `CHK(n, 1)
        `CHK(q0, {~^8'h55, 11'h055})
        rx_go(11'h13C, 1'b1);
        `CHK(n, 2)
        `CHK(q0, {~^8'h3C, 11'h13C})
        `CHK(q1, {~^K285_CHAR, K285_STAT, K285_CHAR})
        `CHK({rx_stat, rx_char}, {{2{K285_STAT}}, {2{K285_CHAR}}})
        wb(1'b0, ADR_STAT, 32'h0, rv);
        `CHK(rv[5:2], 4'h3)
    endtask : t_ebuf

    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    // Main sequence
    initial begin
        {cyc, stb, we, adr, sel, wdat, rx_word, rx_frm, rx_val} = '0;
        {err_total, check_count, reset_n} = '0;
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_static();
        t_tx();
        t_irq();
        t_rx();
        t_ebuf();
        test_done();
    end
endmodule : pfrc_top_tb

// Checker attached to the top module
bind pfrc_top pfrc_top_checker u_pfrc_top_checker (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O), .TX_VALID_IN(TX_VALID_IN),
    .TX_VALID_OUT(TX_VALID_OUT), .TX_PARITY_ERR(TX_PARITY_ERR), .RX_IN_FRAMING(RX_IN_FRAMING),
    .RX_IN_VALID(RX_IN_VALID), .RX_CHAR_OUT(RX_CHAR_OUT), .RX_STATUS_OUT(RX_STATUS_OUT),
    .RX_VALID_OUT(RX_VALID_OUT), .RX_PARITY_OUT(RX_PARITY_OUT), .RX_PARITY_OE(RX_PARITY_OE),
    .DELAYED_REF_CLOCK_OUT(DELAYED_REF_CLOCK_OUT), .DELAYED_REF_CLOCK_OE(DELAYED_REF_CLOCK_OE),
    .PLL_RANGE_OUT(PLL_RANGE_OUT));
